//--- shared/gpem_params.svh
`ifndef GPEM_PARAMS_SVH
`define GPEM_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define GPEM_OFF_PIN_ENABLE    8'h00
`define GPEM_OFF_PIN_DIRECTION 8'h04
`define GPEM_OFF_PIN_VALUE     8'h08
`define GPEM_OFF_RISE_FLAGS    8'h0C
`define GPEM_OFF_FALL_FLAGS    8'h10
`define GPEM_OFF_HIGH_MASK     8'h14
`define GPEM_OFF_LOW_MASK      8'h18
`define GPEM_OFF_GLOBAL_CTRL   8'h1C
`define GPEM_OFF_IRQ_STATUS    8'h20
`define GPEM_OFF_IRQ_MASK      8'h24

// ----------------------------------------------------------------------
// Global control field positions
// ----------------------------------------------------------------------
`define GPEM_GC_PIN0_SEL   5
`define GPEM_GC_LINE0_MODE 4
`define GPEM_GC_POLARITY   2
`define GPEM_GC_AND_SEL    1
`define GPEM_GC_DV_SEL     0

// ----------------------------------------------------------------------
// Interrupt status bits, reset values, bus answers
// ----------------------------------------------------------------------
`define GPEM_IRQ_LINE0     0
`define GPEM_IRQ_FLAG      1
`define GPEM_IRQ_W         2
`define GPEM_RST_ZERO      1'h0
`define GPEM_RESP_OKAY     2'h0
`define GPEM_RESP_SLVERR   2'h2

`endif

//--- shared/gpem_pkg.sv
package gpem_pkg;

   // ----------------------------------------------------------------------
   // Global control fields, packed in register order
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic pinZeroOutputSelect;  // Pin zero drives combined signal
      logic lineZeroModeSelect;   // Line zero from combined logic
      logic combinedPolarity;     // Invert the combination result
      logic andCombineSelect;     // AND instead of OR
      logic deltaValueSelect;     // Levels instead of transitions
   } gpem_ctrl_t;

endpackage

//--- design/gpem_top.sv
// Overview of operation
// - Low mask upper sixteen bits read zero
// - Cleared low mask bit blocks that pin
// - Set low mask passes falling flag/value
// - Control reserved bits read zero, ignore writes
// - Pin zero output shows value bit
// - Pin zero output shows combined signal
// - Pass-through: line zero follows pin zero
// - Logic mode: line zero follows combination
// - Polarity bit inverts combination result
// - OR of all masked pin events
// - AND of all masked pin events
// - Delta select uses transition flags
// - Value select uses current pin levels
// - Logic options matter only in logic mode or with pin zero output select
// - Falling flag sets, clears by one
// - High mask passes rising flag/value
`include "gpem_params.svh"

module gpem_top #(
   parameter int PIN_COUNT = 16                // Pins, at most 16
) (
   input  wire logic                 ref_clk,
   input  wire logic                 arst_n,
   input  wire logic [31:0]          awaddr,
   input  wire logic                 awvalid,
   output      logic                 awready,
   input  wire logic [31:0]          wdata,
   input  wire logic [3:0]           wstrb,
   input  wire logic                 wvalid,
   output      logic                 wready,
   output      logic [1:0]           bresp,
   output      logic                 bvalid,
   input  wire logic                 bready,
   input  wire logic [31:0]          araddr,
   input  wire logic                 arvalid,
   output      logic                 arready,
   output      logic [31:0]          rdata,
   output      logic [1:0]           rresp,
   output      logic                 rvalid,
   input  wire logic                 rready,
   input  wire logic [PIN_COUNT-1:0] pinIn,
   output      logic [PIN_COUNT-1:0] pinOut,
   output      logic [PIN_COUNT-1:0] pinOeN,
   output      logic                 eventLineZero,
   output      logic                 combinedEvent,
   output      logic                 irq
);

   localparam int PAD = 32 - PIN_COUNT;        // Zero bits above pins

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   logic [PIN_COUNT-1:0] sync1_q;              // First synchroniser stage
   logic [PIN_COUNT-1:0] pinSync_q;            // Second stage, safe to use
   logic [PIN_COUNT-1:0] pinPrev_q;            // Previous level, for edges
   logic [PIN_COUNT-1:0] enable_q;             // Pin enable bits
   logic [PIN_COUNT-1:0] direction_q;          // One means output
   logic [PIN_COUNT-1:0] valOut_q;             // Software value for outputs
   logic [PIN_COUNT-1:0] rise_q;               // Rising transition flags
   logic [PIN_COUNT-1:0] fall_q;               // Falling transition flags
   logic [PIN_COUNT-1:0] highMask_q;           // High event mask
   logic [PIN_COUNT-1:0] lowMask_q;            // Low event mask
   gpem_pkg::gpem_ctrl_t ctrl_q;               // Global control
   logic [`GPEM_IRQ_W-1:0] irqStat_q;          // Sticky interrupt status
   logic [`GPEM_IRQ_W-1:0] irqMask_q;          // Interrupt enables
   logic [PIN_COUNT-1:0] pinOut_q;             // Registered pin drive
   logic [PIN_COUNT-1:0] pinOeN_q;             // Registered enables
   logic                 line0_q;              // Event line zero
   logic                 comb_q;               // Combined signal out
   logic                 irq_q;                // Interrupt level

   // Bus slave state
   logic                 awHeld_q;             // Write address captured
   logic                 wHeld_q;              // Write data captured
   logic [31:0]          wAddr_q;
   logic [31:0]          wData_q;
   logic [3:0]           wStrb_q;
   logic                 awReady_q;
   logic                 wReady_q;
   logic                 bValid_q;
   logic [1:0]           bResp_q;
   logic                 arReady_q;
   logic                 rValid_q;
   logic [31:0]          rData_q;
   logic [1:0]           rResp_q;

   // ----------------------------------------------------------------------
   // Bus handshake decode
   // ----------------------------------------------------------------------
   wire awTake  = awvalid & awReady_q;
   wire wTake   = wvalid & wReady_q;
   // Write commits once both halves are in and no response is pending
   wire doWrite = awHeld_q & wHeld_q & ~bValid_q;
   wire awHeldD = doWrite ? 1'b0 : (awHeld_q | awTake);
   wire wHeldD  = doWrite ? 1'b0 : (wHeld_q | wTake);
   wire bValidD = doWrite ? 1'b1 : (bValid_q & ~bready);
   wire arTake  = arvalid & arReady_q;
   wire rValidD = arTake ? 1'b1 : (rValid_q & ~rready);

   // Byte lanes expanded to a bit mask
   wire [31:0] strbMask = {{8{wStrb_q[3]}}, {8{wStrb_q[2]}},
                           {8{wStrb_q[1]}}, {8{wStrb_q[0]}}};
   wire [PIN_COUNT-1:0] bitMask = strbMask[PIN_COUNT-1:0];
   wire [PIN_COUNT-1:0] wBits   = wData_q[PIN_COUNT-1:0] & bitMask;
   wire wLane0 = wStrb_q[0];
   wire wHigh  = wAddr_q[31:8] == 24'h00_0000;

   wire selEn   = doWrite & wHigh & (wAddr_q[7:0] == `GPEM_OFF_PIN_ENABLE);
   wire selDir  = doWrite & wHigh &
                  (wAddr_q[7:0] == `GPEM_OFF_PIN_DIRECTION);
   wire selVal  = doWrite & wHigh & (wAddr_q[7:0] == `GPEM_OFF_PIN_VALUE);
   wire selRise = doWrite & wHigh & (wAddr_q[7:0] == `GPEM_OFF_RISE_FLAGS);
   wire selFall = doWrite & wHigh & (wAddr_q[7:0] == `GPEM_OFF_FALL_FLAGS);
   wire selHm   = doWrite & wHigh & (wAddr_q[7:0] == `GPEM_OFF_HIGH_MASK);
   wire selLm   = doWrite & wHigh & (wAddr_q[7:0] == `GPEM_OFF_LOW_MASK);
   wire selGc   = doWrite & wHigh & (wAddr_q[7:0] == `GPEM_OFF_GLOBAL_CTRL);
   wire selIs   = doWrite & wHigh & (wAddr_q[7:0] == `GPEM_OFF_IRQ_STATUS);
   wire selIm   = doWrite & wHigh & (wAddr_q[7:0] == `GPEM_OFF_IRQ_MASK);
   wire wMapped = selEn | selDir | selVal | selRise | selFall | selHm |
                  selLm | selGc | selIs | selIm;

   // Byte-lane merge of a pin-wide register
   wire [PIN_COUNT-1:0] enD  = (enable_q & ~bitMask) | wBits;
   wire [PIN_COUNT-1:0] dirD = (direction_q & ~bitMask) | wBits;
   wire [PIN_COUNT-1:0] valD = (valOut_q & ~bitMask) | wBits;
   wire [PIN_COUNT-1:0] hmD  = (highMask_q & ~bitMask) | wBits;
   wire [PIN_COUNT-1:0] lmD  = (lowMask_q & ~bitMask) | wBits;
   // Only the five defined control bits are stored
   wire [31:0] gcW = wData_q;
   gpem_pkg::gpem_ctrl_t gcD;
   assign gcD = wLane0 ? {gcW[`GPEM_GC_PIN0_SEL], gcW[`GPEM_GC_LINE0_MODE],
                          gcW[`GPEM_GC_POLARITY], gcW[`GPEM_GC_AND_SEL],
                          gcW[`GPEM_GC_DV_SEL]} : ctrl_q;

   // ----------------------------------------------------------------------
   // Pin eligibility and transition detection
   // ----------------------------------------------------------------------
   // Only enabled inputs may take part in events
   wire [PIN_COUNT-1:0] inputPins = enable_q & ~direction_q;
   wire [PIN_COUNT-1:0] riseSeen = pinSync_q & ~pinPrev_q & inputPins;
   wire [PIN_COUNT-1:0] fallSeen = ~pinSync_q & pinPrev_q & inputPins;
   // Set wins over a write-one clear in the same cycle
   wire [PIN_COUNT-1:0] riseClr = selRise ? wBits : {PIN_COUNT{1'b0}};
   wire [PIN_COUNT-1:0] fallClr = selFall ? wBits : {PIN_COUNT{1'b0}};
   wire [PIN_COUNT-1:0] riseD = (rise_q & ~riseClr) | riseSeen;
   wire [PIN_COUNT-1:0] fallD = (fall_q & ~fallClr) | fallSeen;
   // Value bits read the pin for inputs, the written value for outputs
   wire [PIN_COUNT-1:0] valueRead = (direction_q & valOut_q) |
                                    (~direction_q & pinSync_q);

   // ----------------------------------------------------------------------
   // Combining logic
   // ----------------------------------------------------------------------
   wire [PIN_COUNT-1:0] hmEff = highMask_q & inputPins;
   wire [PIN_COUNT-1:0] lmEff = lowMask_q & inputPins;
   // Delta select picks flags, value select picks levels
   wire [PIN_COUNT-1:0] hiSrc = ctrl_q.deltaValueSelect ?
                                pinSync_q : rise_q;
   wire [PIN_COUNT-1:0] loSrc = ctrl_q.deltaValueSelect ?
                                ~pinSync_q : fall_q;
   wire orTerm  = |((hmEff & hiSrc) | (lmEff & loSrc));
   wire anyMask = |(hmEff | lmEff);
   // An empty AND would be vacuously true; treat it as false instead
   wire andTerm = anyMask &
                  (&((~hmEff | hiSrc) & (~lmEff | loSrc)));
   wire comboTrue = ctrl_q.andCombineSelect ? andTerm : orTerm;
   wire combined  = comboTrue ^ ctrl_q.combinedPolarity;
   // Logic options steer only the pin zero combined drive while line zero is pass-through
   wire line0D = ctrl_q.lineZeroModeSelect ?
                 combined : valueRead[0];
   wire combD  = ctrl_q.lineZeroModeSelect & combined;
   wire pin0D  = (direction_q[0] & ctrl_q.pinZeroOutputSelect) ?
                 combined : valOut_q[0];

   wire [PIN_COUNT-1:0] pinOutD = {valOut_q[PIN_COUNT-1:1], pin0D};
   wire [PIN_COUNT-1:0] oeND    = ~(enable_q & direction_q);

   // Interrupt events and level
   wire [`GPEM_IRQ_W-1:0] irqSet = {|(riseSeen | fallSeen), line0D & ~line0_q};
   wire [`GPEM_IRQ_W-1:0] irqClr = selIs & wLane0 ?
                                   wData_q[`GPEM_IRQ_W-1:0] : 2'h0;
   wire [`GPEM_IRQ_W-1:0] irqStatD = (irqStat_q & ~irqClr) | irqSet;
   wire [`GPEM_IRQ_W-1:0] irqMaskD = selIm & wLane0 ?
                                     wData_q[`GPEM_IRQ_W-1:0] : irqMask_q;

   // ----------------------------------------------------------------------
   // Read mux
   // ----------------------------------------------------------------------
   wire [31:0] gcRead = {26'h000_0000, ctrl_q.pinZeroOutputSelect,
                         ctrl_q.lineZeroModeSelect, 1'b0,
                         ctrl_q.combinedPolarity, ctrl_q.andCombineSelect,
                         ctrl_q.deltaValueSelect};
   wire [PAD-1:0] zPad = {PAD{1'b0}};
   wire rHigh = araddr[31:8] == 24'h00_0000;
   logic [31:0] rMux;
   logic        rHit;
   always_comb begin
      rHit = rHigh;
      case (araddr[7:0])
         `GPEM_OFF_PIN_ENABLE:    rMux = {zPad, enable_q};
         `GPEM_OFF_PIN_DIRECTION: rMux = {zPad, direction_q};
         `GPEM_OFF_PIN_VALUE:     rMux = {zPad, valueRead};
         `GPEM_OFF_RISE_FLAGS:    rMux = {zPad, rise_q};
         `GPEM_OFF_FALL_FLAGS:    rMux = {zPad, fall_q};
         `GPEM_OFF_HIGH_MASK:     rMux = {zPad, highMask_q};
         `GPEM_OFF_LOW_MASK:      rMux = {zPad, lowMask_q};
         `GPEM_OFF_GLOBAL_CTRL:   rMux = gcRead;
         `GPEM_OFF_IRQ_STATUS:    rMux = {30'h0000_0000, irqStat_q};
         `GPEM_OFF_IRQ_MASK:      rMux = {30'h0000_0000, irqMask_q};
         default: begin
            rMux = 32'h0000_0000;
            rHit = 1'b0;
         end
      endcase
      if (!rHigh) begin
         rMux = 32'h0000_0000;
      end
   end

   // ----------------------------------------------------------------------
   // Pin synchroniser and edge history
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_q   <= {PIN_COUNT{`GPEM_RST_ZERO}};
         pinSync_q <= {PIN_COUNT{`GPEM_RST_ZERO}};
         pinPrev_q <= {PIN_COUNT{`GPEM_RST_ZERO}};
      end else begin
         sync1_q   <= pinIn;
         pinSync_q <= sync1_q;
         pinPrev_q <= pinSync_q;
      end
   end

   // ----------------------------------------------------------------------
   // Software registers and flags
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         enable_q    <= {PIN_COUNT{`GPEM_RST_ZERO}};
         direction_q <= {PIN_COUNT{`GPEM_RST_ZERO}};
         valOut_q    <= {PIN_COUNT{`GPEM_RST_ZERO}};
         highMask_q  <= {PIN_COUNT{`GPEM_RST_ZERO}};
         lowMask_q   <= {PIN_COUNT{`GPEM_RST_ZERO}};
         rise_q      <= {PIN_COUNT{`GPEM_RST_ZERO}};
         fall_q      <= {PIN_COUNT{`GPEM_RST_ZERO}};
         ctrl_q      <= '{default: `GPEM_RST_ZERO};
         irqStat_q   <= {`GPEM_IRQ_W{`GPEM_RST_ZERO}};
         irqMask_q   <= {`GPEM_IRQ_W{`GPEM_RST_ZERO}};
      end else begin
         enable_q    <= selEn  ? enD  : enable_q;
         direction_q <= selDir ? dirD : direction_q;
         valOut_q    <= selVal ? valD : valOut_q;
         highMask_q  <= selHm  ? hmD  : highMask_q;
         lowMask_q   <= selLm  ? lmD  : lowMask_q;
         ctrl_q      <= selGc  ? gcD  : ctrl_q;
         rise_q      <= riseD;
         fall_q      <= fallD;
         irqStat_q   <= irqStatD;
         irqMask_q   <= irqMaskD;
      end
   end

   // ----------------------------------------------------------------------
   // Registered outputs
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         pinOut_q <= {PIN_COUNT{`GPEM_RST_ZERO}};
         pinOeN_q <= {PIN_COUNT{1'h1}};
         line0_q  <= `GPEM_RST_ZERO;
         comb_q   <= `GPEM_RST_ZERO;
         irq_q    <= `GPEM_RST_ZERO;
      end else begin
         pinOut_q <= pinOutD;
         pinOeN_q <= oeND;
         line0_q  <= line0D;
         comb_q   <= combD;
         irq_q    <= |(irqStat_q & irqMask_q);
      end
   end

   // ----------------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------------
   // Ready flags are registered so every bus output comes from a flop
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         awHeld_q  <= 1'b0;
         wHeld_q   <= 1'b0;
         wAddr_q   <= 32'h0000_0000;
         wData_q   <= 32'h0000_0000;
         wStrb_q   <= 4'h0;
         awReady_q <= 1'b0;
         wReady_q  <= 1'b0;
         bValid_q  <= 1'b0;
         bResp_q   <= `GPEM_RESP_OKAY;
         arReady_q <= 1'b0;
         rValid_q  <= 1'b0;
         rData_q   <= 32'h0000_0000;
         rResp_q   <= `GPEM_RESP_OKAY;
      end else begin
         awHeld_q  <= awHeldD;
         wHeld_q   <= wHeldD;
         wAddr_q   <= awTake ? awaddr : wAddr_q;
         wData_q   <= wTake ? wdata : wData_q;
         wStrb_q   <= wTake ? wstrb : wStrb_q;
         awReady_q <= ~awHeldD & ~bValidD;
         wReady_q  <= ~wHeldD & ~bValidD;
         bValid_q  <= bValidD;
         bResp_q   <= doWrite ? (wMapped ? `GPEM_RESP_OKAY :
                                 `GPEM_RESP_SLVERR) : bResp_q;
         arReady_q <= ~rValidD;
         rValid_q  <= rValidD;
         rData_q   <= arTake ? rMux : rData_q;
         rResp_q   <= arTake ? (rHit ? `GPEM_RESP_OKAY :
                                `GPEM_RESP_SLVERR) : rResp_q;
      end
   end

   assign awready       = awReady_q;
   assign wready        = wReady_q;
   assign bvalid        = bValid_q;
   assign bresp         = bResp_q;
   assign arready       = arReady_q;
   assign rvalid        = rValid_q;
   assign rdata         = rData_q;
   assign rresp         = rResp_q;
   assign pinOut        = pinOut_q;
   assign pinOeN        = pinOeN_q;
   assign eventLineZero = line0_q;
   assign combinedEvent = comb_q;
   assign irq           = irq_q;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   sequence seqFallPin0;
      inputPins[0] & pinPrev_q[0] & ~pinSync_q[0];
   endsequence

   sequence seqOrLogic;
      ctrl_q.lineZeroModeSelect & ~ctrl_q.andCombineSelect &
      ~ctrl_q.combinedPolarity;
   endsequence

   a_low_mask_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
      arTake & rHigh & (araddr[7:0] == `GPEM_OFF_LOW_MASK)
      |=> rData_q[31:16] == 16'h0000)
      else $error("low mask upper bits not zero");

   a_gc_reserved: assert property (@(posedge ref_clk) disable iff (!arst_n)
      arTake & rHigh & (araddr[7:0] == `GPEM_OFF_GLOBAL_CTRL)
      |=> (rData_q[31:6] == 26'h000_0000) && !rData_q[3])
      else $error("control reserved bits not zero");

   a_unmasked_quiet: assert property (@(posedge ref_clk) disable iff (!arst_n)
      seqOrLogic ##0 ((hmEff | lmEff) == {PIN_COUNT{1'b0}})
      |=> !line0_q)
      else $error("line zero high with no masked pin");

   a_pin0_value: assert property (@(posedge ref_clk) disable iff (!arst_n)
      direction_q[0] & ~ctrl_q.pinZeroOutputSelect
      |=> pinOut_q[0] == $past(valOut_q[0]))
      else $error("pin zero not driving value bit");

   a_pin0_comb: assert property (@(posedge ref_clk) disable iff (!arst_n)
      direction_q[0] & ctrl_q.pinZeroOutputSelect & ~pinOeN_q[0]
      |=> pinOut_q[0] == $past(comboTrue ^ ctrl_q.combinedPolarity))
      else $error("pin zero not driving combined signal");

   a_pass_line0: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ~ctrl_q.lineZeroModeSelect
      |=> line0_q == $past(valueRead[0]) && !comb_q)
      else $error("pass-through line zero wrong");

   a_logic_line0: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctrl_q.lineZeroModeSelect & ctrl_q.combinedPolarity & ~comboTrue
      |=> line0_q && comb_q)
      else $error("inverted combination not asserted");

   a_or_value: assert property (@(posedge ref_clk) disable iff (!arst_n)
      seqOrLogic ##0 (ctrl_q.deltaValueSelect & |(lmEff & ~pinSync_q))
      |=> line0_q)
      else $error("value OR missed a low pin");

   a_or_delta: assert property (@(posedge ref_clk) disable iff (!arst_n)
      seqOrLogic ##0 (~ctrl_q.deltaValueSelect & |(hmEff & rise_q))
      |=> line0_q)
      else $error("delta OR missed a rising flag");

   a_and_miss: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ctrl_q.lineZeroModeSelect & ctrl_q.andCombineSelect &
      ~ctrl_q.combinedPolarity & |(lmEff & ~loSrc)
      |=> !line0_q)
      else $error("AND true with a missing event");

   a_fall_sets: assert property (@(posedge ref_clk) disable iff (!arst_n)
      seqFallPin0 |=> fall_q[0] [*2])
      else $error("falling flag not set or not sticky");

   a_fall_holds: assert property (@(posedge ref_clk) disable iff (!arst_n)
      ~inputPins[0] & ~fallClr[0] |=> $stable(fall_q[0]))
      else $error("falling flag changed on output pin");

endmodule

//--- bench/gpem_pin_model.sv
// ----------------------------------------------------------------------
// Pin-side partner: external drivers meet the block's own pin drive
// ----------------------------------------------------------------------
module gpem_pin_model #(
   parameter int N = 16                  // Pin count
) (
   input  wire logic [N-1:0] pinOut,     // Block drive value
   input  wire logic [N-1:0] pinOeN,     // Low while block drives
   input  wire logic [N-1:0] extDrive,   // Outside world level
   output      logic [N-1:0] pinIn       // Resolved wire level
);
   timeunit 1ns;
   timeprecision 1ps;
   // Block wins where it drives, so no contention is modelled
   assign pinIn = (pinOut & ~pinOeN) | (extDrive & pinOeN);
endmodule

//--- bench/tb_gpio_event_mask_global_ctrl.sv
`include "gpem_params.svh"
module tb_gpio_event_mask_global_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Stimulus, observed outputs, counters
   // ----------------------------------------------------------------
   logic ref_clk = 1'b0, arst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
   logic bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rv;
   logic [3:0]  wstrb = 4'hF;
   logic [1:0]  bresp, rresp, rsp;
   logic [31:0] rdata;
   logic awready, wready, bvalid, arready, rvalid;
   logic eventLineZero, combinedEvent, irq;
   logic [15:0] pinIn, pinOut, pinOeN, extDrive = 16'h0;
   int n_errors = 0, checks = 0;
   localparam logic [7:0] GC = `GPEM_OFF_GLOBAL_CTRL;
   localparam logic [7:0] LM = `GPEM_OFF_LOW_MASK;
   localparam logic [7:0] HM = `GPEM_OFF_HIGH_MASK;
   always #2 ref_clk = ~ref_clk;         // 250 MHz
   gpem_top #(.PIN_COUNT(16)) dut_u (.ref_clk, .arst_n, .awaddr,
      .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
      .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .pinIn, .pinOut, .pinOeN, .eventLineZero,
      .combinedEvent, .irq);
   gpem_pin_model #(.N(16)) pins_u (.pinOut, .pinOeN, .extDrive, .pinIn);
   // ----------------------------------------------------------------
   // Bus tasks: hold each channel until its own ready is sampled
   // ----------------------------------------------------------------
   task automatic w(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      awaddr <= {24'h0, a}; wdata <= d;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rsp = bresp;
      bready <= 1'b0;
   endtask
   task automatic r(input logic [7:0] a);
      @(posedge ref_clk);
      araddr <= {24'h0, a}; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rv = rdata; rsp = rresp;
      rready <= 1'b0;
   endtask
   // Pins need sync plus flag plus output stages before outputs show
   task automatic p(input logic [15:0] v);
      @(posedge ref_clk);
      extDrive <= v;
      repeat (6) @(posedge ref_clk);
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Hang guard, far beyond the few hundred cycles of the tests
   initial begin
      #100000;
      n_errors++;
      tally_and_finish();
   end
   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(posedge ref_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      r(LM); chk(rv, 32'h0); r(GC); chk(rv, 32'h0);
      w(LM, 32'hFFFFFFFF); r(LM); chk(rv, 32'h0000FFFF);
      w(GC, 32'hFFFFFFFF); chk(rsp, `GPEM_RESP_OKAY); r(GC);
      chk(rv, 32'h00000037);
      // Unmapped offsets answer with an error and change nothing
      r(8'hFC); chk(rsp, `GPEM_RESP_SLVERR); chk(rv, 32'h0);
      w(8'hFC, 32'hFFFFFFFF); chk(rsp, `GPEM_RESP_SLVERR);
      $display("test registers done");
      // Value mode OR, one low-mask pin held low; control set before the mask
      w(`GPEM_OFF_PIN_ENABLE, 32'h3); w(GC, 32'h11);
      w(LM, 32'h2); p(0);
      chk(combinedEvent, 1); chk(eventLineZero, 1);
      w(LM, 32'h0); p(0); chk(combinedEvent, 0);
      w(HM, 32'h1); p(1); chk(combinedEvent, 1);
      w(`GPEM_OFF_PIN_DIRECTION, 32'h1); p(1); chk(combinedEvent, 0);
      w(`GPEM_OFF_PIN_DIRECTION, 32'h0); w(LM, 32'h2); w(GC, 32'h13);
      p(1); chk(combinedEvent, 1); p(3); chk(combinedEvent, 0);
      w(GC, 32'h17); p(3); chk(combinedEvent, 1);
      // Delta mode: falling flag of pin 1 drives the combination
      w(GC, 32'h10); w(HM, 32'h0); w(`GPEM_OFF_FALL_FLAGS, 32'hFFFF);
      p(3); chk(combinedEvent, 0); p(1); chk(combinedEvent, 1);
      r(`GPEM_OFF_FALL_FLAGS); chk(rv, 32'h2);
      w(`GPEM_OFF_FALL_FLAGS, 32'h2); p(1); chk(combinedEvent, 0);
      $display("test combine done");
      // Pass-through with polarity set: options must not matter
      w(GC, 32'h4); w(`GPEM_OFF_IRQ_MASK, 32'h0); p(0);
      chk(eventLineZero, 0); chk(combinedEvent, 0);
      w(`GPEM_OFF_IRQ_STATUS, 32'h3); p(1); chk(eventLineZero, 1);
      chk(irq, 0); r(`GPEM_OFF_IRQ_STATUS); chk(rv[0], 1);
      w(`GPEM_OFF_IRQ_MASK, 32'h1); p(1); chk(irq, 1);
      w(`GPEM_OFF_IRQ_STATUS, 32'h1); p(1); chk(irq, 0);
      // Pin zero as output: value bit, then combined signal
      w(`GPEM_OFF_PIN_DIRECTION, 32'h1); w(`GPEM_OFF_PIN_VALUE, 32'h1);
      w(GC, 32'h0); p(3); chk(pinOut, 16'h0001); chk(pinOeN, 16'hFFFE);
      w(`GPEM_OFF_PIN_VALUE, 32'h0); w(GC, 32'h25); p(3);
      chk(pinOut, 16'h0001); chk(combinedEvent, 0);
      $display("test pins done");
      tally_and_finish();
   end
endmodule
